//--- dshs_crc16.sv
// One-byte update of the header check word.
`timescale 1ns/100ps
`default_nettype none
module dshs_crc16
   import dshs_pkg::*;
(
   // Running check word and the byte being added.
   input wire logic [15:0] crc_in,
   input wire logic [7:0] data_in,
   // Updated check word.
   output logic [15:0] crc_out
);

   // Bit-serial division unrolled over the eight bits of the byte.
   always_comb begin
      crc_out = crc_in ^ {data_in, 8'h00};
      for (int i = 0; i < 8; i++) begin
         if (crc_out[15]) begin
            crc_out = {crc_out[14:0], 1'b0} ^ CRC_POLY;
         end else begin
            crc_out = {crc_out[14:0], 1'b0};
         end
      end
   end

endmodule
`default_nettype wire

//--- dshs_host_model.sv
// Controller model that hands header words over on request.
`timescale 1ns/100ps
`default_nettype none
module dshs_host_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Restart of the word order and the words, word 1 on top.
   input wire logic restart,
   input wire logic [63:0] words,
   // Word handshake.
   input wire logic word_req,
   output logic host_wr,
   output logic [15:0] host_data
);
   // ------------------------------------------------------------------
   // Answer logic
   // ------------------------------------------------------------------
   logic [1:0] idx; // Next word to hand over.
   // Each request is answered one cycle later, the latest that is safe.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         idx <= 2'h0;
         host_wr <= 1'b0;
         host_data <= 16'h0000;
      end else if (restart) begin
         idx <= 2'h0;
         host_wr <= 1'b0;
      end else if (word_req) begin
         host_wr <= 1'b1;
         host_data <= words[63 - 16 * idx -: 16];
         idx <= idx + 2'h1;
      end else begin
         // Released lines keep changing, so a stale word never matches.
         host_wr <= 1'b0;
         host_data <= ~host_data;
      end
   end
endmodule
`default_nettype wire

//--- dshs_pkg.sv
// Constants shared by the disk sector header sequencer.
// What this block does
// - Four commands: octal 63, 61, 73, 71.
// - Formatting sets sector-found and format flags.
// - Sector pulse clears byte counter before counting.
// - Sector-found set when sector count equals target.
// - Formatting pre-header sends first word request.
// - Zeros until count 39, then sync byte.
// - Loading the sync byte clears byte counter.
// - Count 39 loads buffer, writes sync, loads word.
// - Each outgoing word requests the next word.
// - Third word written, then fourth loaded, written.
// - Count 30 sets read enable and sync strobe.
// - Sync detected while reading sets header region.
// - Sync detected while reading clears byte counter.
// - Read words assembled, then moved to buffer.
// - Count 02 compares cylinder word, flags match.
// - Count 04 compares sector/track, flags full match.
// - Key words pass through, never steer control.
// - Header read command requests all four words.
// - Pre-header is 40 zeros plus sync 98h.
// - Sector in bits 0-4, track in 8-12.
// - Header check sets error or header-found.
package dshs_pkg;

   // ------------------------------------------------------------------
   // Command codes
   // ------------------------------------------------------------------
   localparam logic [5:0] CMD_FORMAT = 6'h33;     // Octal 63.
   localparam logic [5:0] CMD_WRITE_DATA = 6'h31; // Octal 61.
   localparam logic [5:0] CMD_READ_HDR = 6'h3B;   // Octal 73.
   localparam logic [5:0] CMD_READ_DATA = 6'h39;  // Octal 71.

   // ------------------------------------------------------------------
   // Field layout and byte counts
   // ------------------------------------------------------------------
   localparam logic [7:0] SYNC_BYTE = 8'h98;       // Pattern 1001 1000.
   localparam logic [5:0] PRE_SYNC_COUNT = 6'h27;  // Byte count 39.
   localparam logic [5:0] READ_EN_COUNT = 6'h1E;   // Byte count 30.
   localparam logic [5:0] CYL_CHECK_COUNT = 6'h02; // Cylinder word done.
   localparam logic [5:0] ADDR_CHECK_COUNT = 6'h04; // Sector/track done.
   localparam logic [5:0] HDR_DATA_BYTES = 6'h08;  // Four header words.
   localparam logic [5:0] CRC_CHECK_COUNT = 6'h0A; // Check word done.
   localparam logic [2:0] HDR_WORDS = 3'h4;        // Words from host.
   localparam int SECTOR_LSB = 0;                  // Sector field base.
   localparam int SECTOR_W = 5;                    // Bits 0 to 4.

   // ------------------------------------------------------------------
   // Header check word and reset values
   // ------------------------------------------------------------------
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] WORD_RESET = 16'h0000;

endpackage

//--- dshs_sync2.sv
// Two-stage synchroniser for asynchronous drive pulses.
`timescale 1ns/100ps
`default_nettype none
module dshs_sync2 #(
   parameter int W = 2
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Raw and synchronised levels.
   input wire logic [W-1:0] d_in,
   output wire logic [W-1:0] d_out
);

   // Both stages live in one state word; only stage two is read out.
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] safe;
   } dshs_sync_t;

   dshs_sync_t s_reg;
   dshs_sync_t s_next;

   // Shift the pins through the two stages.
   always_comb begin
      s_next.meta = d_in;
      s_next.safe = s_reg.meta;
   end

   // Registers take a constant under reset.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign d_out = s_reg.safe;

endmodule
`default_nettype wire

//--- dshs_top.sv
// Sector start sequencer: pre-header, sync and header words.
`timescale 1ns/100ps
`default_nettype none
module dshs_top
   import dshs_pkg::*;
(
   // Clock and reset.
   input wire logic REF_CLK,
   input wire logic RST_B,
   // Command from the controller.
   input wire logic GO,
   input wire logic [5:0] CMD,
   input wire logic [15:0] DESIRED_CYL,
   input wire logic [15:0] DESIRED_SECTRK,
   // Drive pulses and read channel.
   input wire logic SECTOR_PULSE,
   input wire logic INDEX_PULSE,
   input wire logic [7:0] RD_BYTE,
   // Write channel.
   output wire logic [7:0] WR_BYTE,
   output wire logic WR_GATE,
   // Controller word handshake.
   output wire logic WORD_REQUEST_STROBE,
   input wire logic HOST_WRITE_STROBE,
   input wire logic [15:0] HOST_DATA,
   output wire logic [15:0] DATA_BUF,
   output wire logic BUFFER_LOAD_CLOCK,
   output wire logic SHIFT_REG_LOAD,
   // Status.
   output wire logic BUSY,
   output wire logic SECTOR_FOUND,
   output wire logic FORMAT_FLAG,
   output wire logic DISK_READ_ENABLE,
   output wire logic SYNC_STROBE,
   output wire logic HEADER_REGION_FLAG,
   output wire logic CYLINDER_MATCH,
   output wire logic FULL_ADDRESS_MATCH,
   output wire logic HEADER_FOUND,
   output wire logic HEADER_CHECK_ERROR
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE, S_WAIT, S_PRE, S_FMT_HDR, S_RD_PRE, S_RD_HUNT, S_RD_HDR
   } dshs_st_t;

   typedef struct packed {
      dshs_st_t st;        // Sequencer phase.
      logic [5:0] cmd;     // Latched command.
      logic [5:0] cnt;     // Byte counter.
      logic [4:0] sector;  // Sector counter.
      logic sp_d;          // Sector pulse, previous sample.
      logic ix_d;          // Index pulse, previous sample.
      logic [15:0] sr;     // Byte shift register.
      logic [15:0] dbuf;   // Data buffer register.
      logic [15:0] hold;   // First word, held until count 39.
      logic [15:0] crc;    // Running header check word.
      logic [2:0] widx;    // Words loaded while formatting.
      logic half;          // Next formatting cycle loads a word.
      logic wr_gate;
      logic word_req;
      logic buf_load;
      logic sr_load;
      logic found;         // Sector found.
      logic fmt;           // Formatting command flag.
      logic read_en;
      logic sync_strobe;
      logic hdr_region;
      logic cyl_match;
      logic all_match;
      logic hdr_found;
      logic hdr_err;
      logic busy;          // Registered copy of "not idle".
   } dshs_state_t;

   dshs_state_t s_reg;
   dshs_state_t s_next;
   logic [1:0] pulse_s;     // Synchronised sector and index pulses.
   logic sp_rise;           // Leading edge of a sector pulse.
   logic ix_rise;           // Leading edge of an index pulse.
   logic [4:0] sec_now;     // Sector count after this pulse.
   logic [7:0] crc_byte;    // Byte entering the check word.
   logic [15:0] crc_upd;    // Check word with that byte added.

   // Decode of the read-type codes, used only by the command latch.
   function automatic logic is_read_cmd(input logic [5:0] c);
      return (c == CMD_WRITE_DATA) || (c == CMD_READ_HDR) ||
             (c == CMD_READ_DATA);
   endfunction

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // The drive pulses are asynchronous, so they are synchronised first.
   dshs_sync2 #(.W(2)) u_sync (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .d_in({INDEX_PULSE, SECTOR_PULSE}),
      .d_out(pulse_s)
   );

   // The check word follows the disk on reads, the writer on formats.
   assign crc_byte = (s_reg.st == S_RD_HDR) ? RD_BYTE : s_reg.sr[15:8];

   dshs_crc16 u_crc (
      .crc_in(s_reg.crc),
      .data_in(crc_byte),
      .crc_out(crc_upd)
   );

   assign sp_rise = pulse_s[0] & ~s_reg.sp_d;
   assign ix_rise = pulse_s[1] & ~s_reg.ix_d;
   assign sec_now = 5'(s_reg.sector + 5'h01);

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      // Request and load strobes last one cycle.
      s_next.word_req = 1'b0;
      s_next.buf_load = 1'b0;
      s_next.sr_load = 1'b0;
      s_next.sp_d = pulse_s[0];
      s_next.ix_d = pulse_s[1];
      // Index restarts the sector count and wins; otherwise a sector pulse advances it.
      if (ix_rise) begin
         s_next.sector = '0;
      end else if (sp_rise) begin
         s_next.sector = sec_now;
      end
      // A new command clears the flags; codes outside the four are
      // ignored so a stray write cannot start the writer.
      if (GO && (CMD == CMD_FORMAT || is_read_cmd(CMD))) begin
         s_next = '{default: '0, st: S_WAIT, cmd: CMD,
                    sector: s_next.sector, sp_d: pulse_s[0],
                    ix_d: pulse_s[1], crc: CRC_INIT};
      end
      // Sets below come from the current phase, so they win over GO.
      unique case (s_reg.st)
         S_IDLE: begin
            s_next.wr_gate = 1'b0;
         end
         S_WAIT: begin
            if (sp_rise) begin
               s_next.cnt = '0;
               s_next.sr = WORD_RESET;
               // Sector field of the target word.
               if (sec_now == DESIRED_SECTRK[SECTOR_LSB +: SECTOR_W])
               begin
                  s_next.found = 1'b1;
                  if (s_reg.cmd == CMD_FORMAT) begin
                     s_next.fmt = 1'b1;
                     s_next.wr_gate = 1'b1;
                     s_next.word_req = 1'b1;
                     s_next.st = S_PRE;
                  end else begin
                     s_next.st = S_RD_PRE;
                  end
               end
            end
         end
         S_PRE: begin
            // Zeros go out; the first word may arrive at any time here.
            s_next.cnt = 6'(s_reg.cnt + 6'h01);
            if (HOST_WRITE_STROBE) begin
               s_next.hold = HOST_DATA;
            end
            if (s_reg.cnt == PRE_SYNC_COUNT) begin
               s_next.sr = {SYNC_BYTE, 8'h00};
               s_next.cnt = '0;
               s_next.buf_load = 1'b1;
               s_next.dbuf = HOST_WRITE_STROBE ? HOST_DATA : s_reg.hold;
               s_next.crc = CRC_INIT;
               s_next.widx = '0;
               s_next.half = 1'b1;
               s_next.st = S_FMT_HDR;
            end
         end
         S_FMT_HDR: begin
            s_next.cnt = 6'(s_reg.cnt + 6'h01);
            if (HOST_WRITE_STROBE) begin
               s_next.dbuf = HOST_DATA;
            end
            // Header bytes (not sync, not check word) feed the check.
            if (s_reg.widx != 3'h0 && s_reg.widx <= HDR_WORDS) begin
               s_next.crc = crc_upd;
            end
            if (!s_reg.half) begin
               // Second byte of the word moves up to the write port.
               s_next.sr = {s_reg.sr[7:0], 8'h00};
               s_next.half = 1'b1;
            end else if (s_reg.widx < HDR_WORDS) begin
               // A word strobed in this very cycle bypasses the buffer,
               // so a controller that answers one cycle late still lands.
               s_next.sr = HOST_WRITE_STROBE ? HOST_DATA :
                           s_reg.dbuf;
               s_next.sr_load = 1'b1;
               s_next.word_req = (s_reg.widx < HDR_WORDS - 3'h1);
               s_next.widx = 3'(s_reg.widx + 3'h1);
               s_next.half = 1'b0;
            end else if (s_reg.widx == HDR_WORDS) begin
               // The check word covers the byte leaving this cycle.
               s_next.sr = crc_upd;
               s_next.sr_load = 1'b1;
               s_next.widx = 3'(s_reg.widx + 3'h1);
               s_next.half = 1'b0;
            end else begin
               s_next.wr_gate = 1'b0;
               s_next.st = S_IDLE;
            end
         end
         S_RD_PRE: begin
            s_next.cnt = 6'(s_reg.cnt + 6'h01);
            if (s_reg.cnt == READ_EN_COUNT) begin
               s_next.read_en = 1'b1;
               s_next.sync_strobe = 1'b1;
               s_next.st = S_RD_HUNT;
            end
         end
         S_RD_HUNT: begin
            // Hunting waits on the disk; a missing sync parks here
            // until the next command.
            s_next.sr = {s_reg.sr[7:0], RD_BYTE};
            if (RD_BYTE == SYNC_BYTE) begin
               s_next.hdr_region = 1'b1;
               s_next.cnt = '0;
               s_next.sync_strobe = 1'b0;
               s_next.crc = CRC_INIT;
               s_next.st = S_RD_HDR;
            end
         end
         S_RD_HDR: begin
            s_next.cnt = 6'(s_reg.cnt + 6'h01);
            s_next.sr = {s_reg.sr[7:0], RD_BYTE};
            if (s_reg.cnt < HDR_DATA_BYTES) begin
               s_next.crc = crc_upd;
            end
            // Each even count from 2 holds a whole word; keys pass unseen.
            if (s_reg.cnt != 6'h00 && !s_reg.cnt[0] &&
                s_reg.cnt <= HDR_DATA_BYTES) begin
               s_next.dbuf = s_reg.sr;
               s_next.buf_load = 1'b1;
               s_next.word_req = (s_reg.cmd == CMD_READ_HDR);
            end
            if (s_reg.cnt == CYL_CHECK_COUNT) begin
               s_next.cyl_match = (s_reg.sr == DESIRED_CYL);
            end
            if (s_reg.cnt == ADDR_CHECK_COUNT) begin
               s_next.all_match = s_reg.cyl_match &&
                                  (s_reg.sr == DESIRED_SECTRK);
            end
            if (s_reg.cnt == CRC_CHECK_COUNT) begin
               s_next.hdr_err = (s_reg.sr != s_reg.crc);
               s_next.hdr_found = (s_reg.sr == s_reg.crc);
               s_next.read_en = 1'b0;
               s_next.hdr_region = 1'b0;
               s_next.st = S_IDLE;
            end
         end
      endcase
      // Busy is registered so that the output comes from a flop.
      s_next.busy = (s_next.st != S_IDLE);
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_reg <= '{default: '0, st: S_IDLE, crc: CRC_INIT};
      end else begin
         s_reg <= s_next;
      end
   end

   // Every output is a field of the state register.
   assign WR_BYTE = s_reg.sr[15:8];
   assign WR_GATE = s_reg.wr_gate;
   assign WORD_REQUEST_STROBE = s_reg.word_req;
   assign DATA_BUF = s_reg.dbuf;
   assign BUFFER_LOAD_CLOCK = s_reg.buf_load;
   assign SHIFT_REG_LOAD = s_reg.sr_load;
   assign BUSY = s_reg.busy;
   assign SECTOR_FOUND = s_reg.found;
   assign FORMAT_FLAG = s_reg.fmt;
   assign DISK_READ_ENABLE = s_reg.read_en;
   assign SYNC_STROBE = s_reg.sync_strobe;
   assign HEADER_REGION_FLAG = s_reg.hdr_region;
   assign CYLINDER_MATCH = s_reg.cyl_match;
   assign FULL_ADDRESS_MATCH = s_reg.all_match;
   assign HEADER_FOUND = s_reg.hdr_found;
   assign HEADER_CHECK_ERROR = s_reg.hdr_err;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);

   a_fmt_sector_hit:
      assert property (s_reg.st == S_WAIT && sp_rise && !GO &&
         s_reg.cmd == CMD_FORMAT &&
         sec_now == DESIRED_SECTRK[4:0] |=>
         SECTOR_FOUND && FORMAT_FLAG && WORD_REQUEST_STROBE)
      else $error("format target sector not flagged");
   a_wait_cnt_clear:
      assert property (s_reg.st == S_WAIT && sp_rise && !GO |=>
         s_reg.cnt == 6'h00)
      else $error("byte counter not cleared at sector pulse");
   a_sync_at_39:
      assert property (s_reg.st == S_PRE && s_reg.cnt == 6'h27 && !GO
         |=> WR_BYTE == 8'h98 && BUFFER_LOAD_CLOCK && s_reg.cnt == 0)
      else $error("sync byte not written at count 39");
   a_word_sequence:
      assert property (s_reg.st == S_FMT_HDR && s_reg.half &&
         s_reg.widx == 3'h0 && !GO |=> SHIFT_REG_LOAD &&
         WORD_REQUEST_STROBE ##1 !SHIFT_REG_LOAD ##1 SHIFT_REG_LOAD)
      else $error("header word loads out of step");
   a_read_enable_30:
      assert property (s_reg.st == S_RD_PRE && s_reg.cnt == 6'h1E &&
         !GO |=> DISK_READ_ENABLE && SYNC_STROBE)
      else $error("read enable not set at count 30");
   a_sync_detect:
      assert property (s_reg.st == S_RD_HUNT && RD_BYTE == 8'h98 &&
         !GO |=> HEADER_REGION_FLAG && !SYNC_STROBE && s_reg.cnt == 0)
      else $error("sync detection did not open the header");
   a_cyl_compare:
      assert property (s_reg.st == S_RD_HDR && s_reg.cnt == 6'h02 &&
         !GO |=> CYLINDER_MATCH == ($past(s_reg.sr) ==
         $past(DESIRED_CYL)))
      else $error("cylinder compare wrong");
   a_addr_compare:
      assert property (s_reg.st == S_RD_HDR && s_reg.cnt == 6'h04 &&
         !GO |=> FULL_ADDRESS_MATCH == ($past(CYLINDER_MATCH) &&
         $past(s_reg.sr) == $past(DESIRED_SECTRK)))
      else $error("sector/track compare wrong");
   a_key_passthru:
      assert property (s_reg.st == S_RD_HDR && s_reg.cnt == 6'h06 &&
         !GO |=> DATA_BUF == $past(s_reg.sr) && BUFFER_LOAD_CLOCK &&
         WORD_REQUEST_STROBE == (s_reg.cmd == 6'h3B) &&
         $stable(FULL_ADDRESS_MATCH))
      else $error("key word not passed to buffer");
   a_check_result:
      assert property (s_reg.st == S_RD_HDR && s_reg.cnt == 6'h0A &&
         !GO |=> (HEADER_FOUND != HEADER_CHECK_ERROR) &&
         !DISK_READ_ENABLE && !BUSY)
      else $error("header check gave no single result");

endmodule
`default_nettype wire

//--- tb_disk_sector_header_sequencer.sv
// Self-checking bench of the sector header sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb_disk_sector_header_sequencer
   import dshs_pkg::*;
;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic ref_clk = 1'b0, rst_b = 1'b0, go = 1'b0, sp = 1'b0, ip = 1'b0;
   logic [5:0] cmd = 6'h00;
   logic [15:0] cyl = 16'h0000, sectrk = 16'h0000;
   logic [7:0] rd_byte = 8'h00;
   logic [63:0] words = 64'h0; // Header words 1 to 4.
   logic host_wr;
   logic [15:0] host_data, data_buf;
   logic [7:0] wr_byte;
   logic wr_gate, wrs, blc, srl, busy, sf, ff, dre, ss, hrf, cm, fam, hf, he;
   int bad_count = 0, compares = 0, n_req = 0, n_load = 0, n_buf = 0;
   logic [7:0] wq[$]; // Bytes seen on the write channel.

   always #5 ref_clk = ~ref_clk;

   dshs_top dshs_top_inst (.REF_CLK(ref_clk), .RST_B(rst_b), .GO(go),
      .CMD(cmd), .DESIRED_CYL(cyl), .DESIRED_SECTRK(sectrk),
      .SECTOR_PULSE(sp), .INDEX_PULSE(ip), .RD_BYTE(rd_byte),
      .WR_BYTE(wr_byte), .WR_GATE(wr_gate), .WORD_REQUEST_STROBE(wrs),
      .HOST_WRITE_STROBE(host_wr), .HOST_DATA(host_data),
      .DATA_BUF(data_buf), .BUFFER_LOAD_CLOCK(blc), .SHIFT_REG_LOAD(srl),
      .BUSY(busy), .SECTOR_FOUND(sf), .FORMAT_FLAG(ff),
      .DISK_READ_ENABLE(dre), .SYNC_STROBE(ss), .HEADER_REGION_FLAG(hrf),
      .CYLINDER_MATCH(cm), .FULL_ADDRESS_MATCH(fam), .HEADER_FOUND(hf),
      .HEADER_CHECK_ERROR(he));

   dshs_host_model dshs_host_model_inst (.clk(ref_clk), .rst_b(rst_b),
      .restart(go), .words(words), .word_req(wrs), .host_wr(host_wr),
      .host_data(host_data));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Outputs are sampled mid-cycle, where they have settled.
   always @(negedge ref_clk) begin
      if (wr_gate === 1'b1) wq.push_back(wr_byte);
      if (wrs === 1'b1) n_req++;
      if (srl === 1'b1) n_load++;
      if (blc === 1'b1) n_buf++;
   end

   // Header check word, worked out independently of the design.
   function automatic logic [15:0] crc16(input logic [63:0] d);
      logic [15:0] c;
      c = CRC_INIT;
      for (int i = 63; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction

   // Expected byte k of the formatted stream.
   function automatic logic [7:0] fmt_byte(input int k);
      logic [79:0] t;
      t = {words, crc16(words)};
      if (k < 40) return 8'h00;
      if (k == 40) return SYNC_BYTE;
      return t[79 - 8 * (k - 41) -: 8];
   endfunction

   task automatic end_sim();
      $display("compares %0d, bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // A wait that ran out is counted and ends the run.
   task automatic timeout(input int n);
      if (n == 0) begin
         check(0, 1);
         end_sim();
      end
   endtask

   // Hold a drive pin high for four cycles, then low for four.
   task automatic pulse(input bit index);
      @(posedge ref_clk);
      if (index) ip <= 1'b1;
      else sp <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ip <= 1'b0;
      sp <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic start(input logic [5:0] c);
      @(posedge ref_clk);
      go <= 1'b1;
      cmd <= c;
      @(posedge ref_clk);
      go <= 1'b0;
      wq = {};
      n_req = 0;
      n_load = 0;
      n_buf = 0;
   endtask

   // Index, then sector 1 passes by, then target sector 2 is reached.
   task automatic find_sector();
      pulse(1'b1);
      pulse(1'b0);
      #1 check(sf, 1'b0);
      pulse(1'b0);
      #1 check(sf, 1'b1);
   endtask

   task automatic wait_idle();
      int n;
      for (n = 2000; n > 0 && busy !== 1'b0; n--) @(posedge ref_clk);
      timeout(n);
      #1;
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      int n;
      logic [5:0] c;
      logic [79:0] hdr;
      void'($urandom(32'h31AA));
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      // An unknown code must leave the block idle.
      start(6'h00);
      #1 check(busy, 1'b0);
      // Formatting a sector with random header words.
      words = {$urandom, $urandom};
      @(posedge ref_clk);
      sectrk <= {3'h0, 5'($urandom), 3'h0, 5'h02};
      start(CMD_FORMAT);
      #1 check(busy, 1'b1);
      find_sector();
      check({sf, ff}, 2'h3);
      wait_idle();
      check(wq.size(), 51);
      for (int k = 0; k < 51; k++) check(wq[k], fmt_byte(k));
      check(n_req, 4);
      check(n_load, 5);
      check(n_buf, 1);
      check(data_buf, words[15:0]);
      // Reads with address and check word faults among them.
      for (int i = 0; i < 6; i++) begin
         c = (i % 3 == 0) ? CMD_WRITE_DATA :
            (i % 3 == 1) ? CMD_READ_HDR : CMD_READ_DATA;
         @(posedge ref_clk);
         cyl <= 16'($urandom);
         sectrk <= {3'h0, 5'($urandom), 3'h0, 5'h02};
         #1;
         words = {cyl ^ 16'(i == 3), sectrk ^ ((i == 4) ? 16'h0100 : 16'h0),
            32'($urandom)};
         hdr = {words, crc16(words) ^ 16'(i == 5)};
         start(c);
         find_sector();
         for (n = 100; n > 0 && dre !== 1'b1; n--) begin
            @(posedge ref_clk);
            #1;
         end
         timeout(n);
         check(ss, 1'b1);
         @(posedge ref_clk);
         rd_byte <= SYNC_BYTE;
         for (int k = 0; k < 10; k++) begin
            @(posedge ref_clk);
            rd_byte <= hdr[79 - 8 * k -: 8];
            if (k == 0) #1 check({hrf, ss}, 2'h2);
         end
         @(posedge ref_clk);
         rd_byte <= 8'h00;
         wait_idle();
         check({cm, fam}, {i != 3, i != 3 && i != 4});
         check({hf, he}, {i != 5, i == 5});
         check(data_buf, words[15:0]);
         check(n_req, (c == CMD_READ_HDR) ? 4 : 0);
         check(n_buf, 4);
         check({dre, hrf}, 2'h0);
      end
      end_sim();
   end
endmodule
`default_nettype wire
